/* File: acd_pkg.sv */
// Package for the analog comparator digital control logic
package acd_pkg;

    // ****************************************************************
    // Register offsets (word index on the plain register port)
    // ****************************************************************
    localparam logic [3:0] ACD_OFS_CONTROL   = 4'h0;
    localparam logic [3:0] ACD_OFS_DAC_BASE  = 4'h4;
    localparam logic [3:0] ACD_OFS_STATUS    = 4'h8;
    localparam logic [3:0] ACD_OFS_IRQ_FLAG  = 4'h9;
    localparam logic [3:0] ACD_OFS_IRQ_MASK  = 4'hA;

    // ****************************************************************
    // Control register field positions (one control register per unit)
    // ****************************************************************
    localparam int ACD_BIT_ENABLE   = 0;
    localparam int ACD_BIT_IDLE     = 1;
    localparam int ACD_BIT_POLARITY = 2;
    localparam int ACD_BIT_DAC_OE   = 3;
    localparam int ACD_BIT_PAD_SRC  = 4;

    localparam logic [15:0] ACD_CONTROL_RESET = 16'h0000;
    localparam logic [15:0] ACD_DAC_RESET     = 16'h0000;

    // ****************************************************************
    // Timing: glitch filter length in instruction cycles
    // ****************************************************************
    localparam int ACD_FILTER_CYCLES = 2;

    // Power mode of the processor as seen by the block
    typedef enum logic [1:0] {
        ACD_MODE_RUN,
        ACD_MODE_IDLE,
        ACD_MODE_SLEEP
    } acd_mode_t;

    // Per-comparator fan-out of the result to the far-side consumers
    typedef struct packed {
        logic adc_trigger;
        logic irq_pulse;
        logic current_limit;
        logic fault;
    } acd_out_t;

endpackage : acd_pkg

/* File: acd_top.sv */
// Digital control logic around a group of analog comparators and reference DACs
`timescale 1ns/1ps

module acd_top
    import acd_pkg::*;
#(
    parameter int NUM_CMP  = 4,
    parameter int DAC_BITS = 10
) (
    input  wire logic                          clk,
    input  wire logic                          srst,
    input  wire logic [3:0]                    reg_addr,
    input  wire logic [15:0]                   reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output      logic [15:0]                   reg_rdata,
    input  wire acd_pkg::acd_mode_t            power_mode,
    input  wire logic [NUM_CMP-1:0]            cmp_raw,
    output      logic [NUM_CMP-1:0]            cmp_power_en,
    output      logic [NUM_CMP-1:0]            dac_power_en,
    output      logic [NUM_CMP*DAC_BITS-1:0]   dac_code,
    output      logic [NUM_CMP-1:0]            pad_digital_buf_off,
    output      logic                          dac_output_pin_en,
    output      logic [$clog2(NUM_CMP)-1:0]    dac_output_pin_sel,
    output      acd_pkg::acd_out_t [NUM_CMP-1:0] cmp_out,
    output      logic [NUM_CMP-1:0]            async_wake,
    output      logic                          irq
);

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    // Refused at elaboration, before any logic is built
    generate
        if (NUM_CMP < 2 || NUM_CMP > 4) begin : g_bad_num_cmp
            $error("NUM_CMP must be 2..4");
        end
        if (DAC_BITS < 1 || DAC_BITS > 16) begin : g_bad_dac_bits
            $error("DAC_BITS must be 1..16");
        end
    endgenerate

    // ****************************************************************
    // Register map (word index on reg_addr)
    // ****************************************************************
    // 0x0..0x3  Control register of units 0..3
    //           bit 0 enable, bit 1 stop in idle, bit 2 invert output,
    //           bit 3 drive the shared DAC pin, bit 4 input from a pad
    // 0x4..0x7  Threshold DAC value of units 0..3, low DAC_BITS bits used
    // 0x8       Filtered comparator levels, read only
    // 0x9       Sticky event flags, write one to clear
    // 0xA       Event mask for the irq output
    // Other     Reads give zero, writes are dropped
    //
    // Bus timing: a write lands on the strobe edge and shows the cycle
    // after; read data stand for the one cycle after the read strobe
    // and are zero otherwise, so an idle bus reads as all zeros.
    // The slave never stalls, so back to back strobes are served.
    // A unit count below four leaves the top indices unmapped.

    // Register index decode, shared by write and read paths
    // Adding the unit index to a base keeps each unit on its own word
    function automatic logic is_unit_reg(input logic [3:0] a, input logic [3:0] base,
                                         input int unit);
        is_unit_reg = (a == base + 4'(unit));
    endfunction : is_unit_reg

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0]        comparator_control_reg      [NUM_CMP];
    logic [15:0]        threshold_dac_value_reg     [NUM_CMP];
    logic [15:0]        next_comparator_control_reg [NUM_CMP];
    logic [15:0]        next_threshold_dac_value_reg[NUM_CMP];
    // Storage notes: control and DAC value registers are kept per unit
    // in flip-flop arrays indexed by unit number; flags and mask hold
    // one bit per unit at the low end of their words.
    logic [NUM_CMP-1:0] irq_flag;
    logic [NUM_CMP-1:0] irq_mask;
    logic [NUM_CMP-1:0] next_irq_flag;
    logic [NUM_CMP-1:0] next_irq_mask;
    logic [15:0]        next_reg_rdata;

    logic [NUM_CMP-1:0] module_on;
    logic [NUM_CMP-1:0] stop_in_idle_bit;
    logic [NUM_CMP-1:0] polarity_inv;
    logic [NUM_CMP-1:0] dac_pin_output_enable;
    logic [NUM_CMP-1:0] pad_source;
    logic [NUM_CMP-1:0] filtered;
    logic [NUM_CMP-1:0] event_pulse;

    // ****************************************************************
    // Field extraction
    // ****************************************************************
    // Field positions come from the package so software and logic agree
    generate
        for (genvar g = 0; g < NUM_CMP; g++) begin : g_fields
            assign module_on[g]             = comparator_control_reg[g][ACD_BIT_ENABLE];
            assign stop_in_idle_bit[g]      = comparator_control_reg[g][ACD_BIT_IDLE];
            assign polarity_inv[g]          = comparator_control_reg[g][ACD_BIT_POLARITY];
            assign dac_pin_output_enable[g] = comparator_control_reg[g][ACD_BIT_DAC_OE];
            assign pad_source[g]            = comparator_control_reg[g][ACD_BIT_PAD_SRC];
        end
    endgenerate

    // Next register values; flag set wins over write-one-to-clear
    always_comb begin
        for (int i = 0; i < NUM_CMP; i++) begin
            next_comparator_control_reg[i]  = comparator_control_reg[i];
            next_threshold_dac_value_reg[i] = threshold_dac_value_reg[i];
            if (reg_wr && is_unit_reg(reg_addr, ACD_OFS_CONTROL, i)) begin
                next_comparator_control_reg[i] = reg_wdata;
            end
            if (reg_wr && is_unit_reg(reg_addr, ACD_OFS_DAC_BASE, i)) begin
                next_threshold_dac_value_reg[i] = reg_wdata;
            end
        end
        next_irq_mask = irq_mask;
        next_irq_flag = irq_flag;
        if (reg_wr && reg_addr == ACD_OFS_IRQ_MASK) begin
            next_irq_mask = reg_wdata[NUM_CMP-1:0];
        end
        if (reg_wr && reg_addr == ACD_OFS_IRQ_FLAG) begin
            next_irq_flag = irq_flag & ~reg_wdata[NUM_CMP-1:0];
        end
        next_irq_flag = next_irq_flag | event_pulse;
        // Read data, zero for unmapped addresses
        next_reg_rdata = 16'h0000;
        if (reg_rd) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                if (is_unit_reg(reg_addr, ACD_OFS_CONTROL, i)) begin
                    next_reg_rdata = comparator_control_reg[i];
                end
                if (is_unit_reg(reg_addr, ACD_OFS_DAC_BASE, i)) begin
                    next_reg_rdata = threshold_dac_value_reg[i];
                end
            end
            if (reg_addr == ACD_OFS_STATUS) begin
                next_reg_rdata = 16'(filtered);
            end
            if (reg_addr == ACD_OFS_IRQ_FLAG) begin
                next_reg_rdata = 16'(irq_flag);
            end
            if (reg_addr == ACD_OFS_IRQ_MASK) begin
                next_reg_rdata = 16'(irq_mask);
            end
        end
    end

    // Register update
    // Synchronous reset clears every register; reset values come from
    // the package. Read data are cleared as well so that the first
    // cycle after reset reads as zero.
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < NUM_CMP; i++) begin
                comparator_control_reg[i]  <= ACD_CONTROL_RESET;
                threshold_dac_value_reg[i] <= ACD_DAC_RESET;
            end
            irq_flag  <= '0;
            irq_mask  <= '0;
            reg_rdata <= 16'h0000;
        end else begin
            comparator_control_reg  <= next_comparator_control_reg;
            threshold_dac_value_reg <= next_threshold_dac_value_reg;
            irq_flag                <= next_irq_flag;
            irq_mask                <= next_irq_mask;
            reg_rdata               <= next_reg_rdata;
        end
    end

    // Level interrupt; stays high until software clears every
    // unmasked flag, so no event is lost between two reads.
    assign irq = |(irq_flag & irq_mask);

    // ****************************************************************
    // Power gating
    // ****************************************************************
    // Idle stop is shared by the whole group: one stop bit set in Idle
    // powers down every unit, not only its owner. Sleep leaves power
    // under control of the enable bits alone, so a unit can still wake
    // the core. A disabled unit's comparator result reads as zero everywhere downstream.
    // The pad buffer follows the enable bit, not the idle stop, so a
    // pad input stays analog while the group sleeps in Idle.
    //
    // One shared idle stop keeps the clock control simple
    logic group_idle_stop;
    logic in_idle;
    logic low_power;
    assign in_idle         = (power_mode == ACD_MODE_IDLE);
    assign low_power       = (power_mode != ACD_MODE_RUN);
    assign group_idle_stop = in_idle && (|stop_in_idle_bit);

    // Polarity is applied before anything else, so the filter, the
    // wake path and every consumer see the same oriented result.
    // Gating by active keeps a powered-down unit from making events.
    logic [NUM_CMP-1:0] active;
    logic [NUM_CMP-1:0] oriented;
    generate
        for (genvar g = 0; g < NUM_CMP; g++) begin : g_unit
            assign active[g]       = module_on[g] && !group_idle_stop;
            assign cmp_power_en[g] = active[g];
            assign dac_power_en[g] = active[g];
            assign dac_code[g*DAC_BITS +: DAC_BITS] =
                threshold_dac_value_reg[g][DAC_BITS-1:0];
            assign pad_digital_buf_off[g] = module_on[g] && pad_source[g];
            assign oriented[g] = (cmp_raw[g] ^ polarity_inv[g]) && active[g];
            // Unclocked wake path, filter bypassed while the clock may stop
            assign async_wake[g] = low_power && oriented[g];
        end
    endgenerate

    // ****************************************************************
    // Glitch filter and event pulse
    // ****************************************************************
    // Timing from a clean input change, in instruction cycles:
    //   edge 1  first sync stage takes the oriented level
    //   edge 2  second stage, now free of metastability
    //   edge 3  sample_prev holds the previous second-stage value
    //   edge 4  two equal samples, filtered level moves
    //   edge 5  event pulse drops, sticky flag is set
    // A level that lives one cycle never gives two equal samples,
    // so it is dropped; two cycles or more pass through.
    // The filter keeps running in Sleep or Idle when a clock is
    // present, but the wake path does not wait for it.
    // Trade-off: four cycles of latency buy immunity to glitches.
    logic [NUM_CMP-1:0] sync1;
    logic [NUM_CMP-1:0] sync2;
    logic [NUM_CMP-1:0] sample_prev;
    logic [NUM_CMP-1:0] filtered_prev;
    logic [NUM_CMP-1:0] next_filtered;

    // Accept a new level only when two samples agree
    always_comb begin
        next_filtered = filtered;
        for (int i = 0; i < NUM_CMP; i++) begin
            if (sync2[i] == sample_prev[i]) begin
                next_filtered[i] = sync2[i];
            end
        end
    end

    // Rising edge of the filtered level; one cycle wide
    assign event_pulse = filtered & ~filtered_prev;

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1         <= '0;
            sync2         <= '0;
            sample_prev   <= '0;
            filtered      <= '0;
            filtered_prev <= '0;
        end else begin
            sync1         <= oriented;
            sync2         <= sync1;
            sample_prev   <= sync2;
            filtered      <= next_filtered;
            filtered_prev <= filtered;
        end
    end

    // Level outputs go to the PWM current limit and fault inputs;
    // pulse outputs go to the ADC trigger and interrupt logic.
    // All consumers see the same result at once
    generate
        for (genvar g = 0; g < NUM_CMP; g++) begin : g_fan
            assign cmp_out[g].adc_trigger   = event_pulse[g];
            assign cmp_out[g].irq_pulse     = event_pulse[g];
            assign cmp_out[g].current_limit = filtered[g];
            assign cmp_out[g].fault         = filtered[g];
        end
    endgenerate

    // ****************************************************************
    // Shared DAC output pin
    // ****************************************************************
    // Software should set at most one pin enable; if it sets several,
    // the lowest index gets the pin and the others are ignored, which
    // keeps the pin from being shorted between two DAC outputs.
    // With no enable set the select rests at zero and en is low.
    // Lowest enabled unit wins, so the pin never has two sources
    logic [$clog2(NUM_CMP)-1:0] next_sel;
    always_comb begin
        next_sel = '0;
        for (int i = NUM_CMP - 1; i >= 0; i--) begin
            if (dac_pin_output_enable[i]) begin
                next_sel = ($clog2(NUM_CMP))'(i);
            end
        end
    end
    assign dac_output_pin_sel = next_sel;
    assign dac_output_pin_en  = |dac_pin_output_enable;

endmodule : acd_top

/* File: acd_top_properties.sv */
// Port-level assertions for the comparator control block
`timescale 1ns/1ps
module acd_top_properties
    import acd_pkg::*;
#(
    parameter int NUM_CMP  = 4,
    parameter int DAC_BITS = 10
) (
    input wire logic                            clk,
    input wire logic                            srst,
    input wire logic [3:0]                      reg_addr,
    input wire logic [15:0]                     reg_wdata,
    input wire logic                            reg_wr,
    input wire acd_pkg::acd_mode_t              power_mode,
    input wire logic [NUM_CMP-1:0]              cmp_raw,
    input wire logic [NUM_CMP-1:0]              cmp_power_en,
    input wire logic [NUM_CMP-1:0]              dac_power_en,
    input wire logic [NUM_CMP*DAC_BITS-1:0]     dac_code,
    input wire logic [NUM_CMP-1:0]              pad_digital_buf_off,
    input wire acd_pkg::acd_out_t [NUM_CMP-1:0] cmp_out,
    input wire logic [NUM_CMP-1:0]              async_wake
);
    // ****************************************************************
    // Unit 0 stands for all units; the logic is replicated
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_pulse_one_cycle: assert property (
        cmp_out[0].irq_pulse |=> !cmp_out[0].irq_pulse) else $error("irq pulse too long");
    a_trig_with_irq: assert property (
        cmp_out[0].adc_trigger == cmp_out[0].irq_pulse) else $error("trigger and irq apart");
    a_limit_with_fault: assert property (
        cmp_out[0].current_limit == cmp_out[0].fault) else $error("limit and fault apart");
    a_pulse_on_level: assert property (
        cmp_out[0].irq_pulse |-> ##[0:1] cmp_out[0].fault) else $error("pulse without level");
    // Equality only, so it holds whatever polarity software chose
    a_hold_before_rise: assert property (
        $rose(cmp_out[0].fault) && power_mode == ACD_MODE_RUN
        |-> $past(cmp_raw[0], 1) == $past(cmp_raw[0], 2)) else $error("filter passed a glitch");
    a_async_quiet_run: assert property (
        power_mode == ACD_MODE_RUN |-> async_wake == '0) else $error("wake path open in run");
    a_async_follow: assert property (
        power_mode == ACD_MODE_SLEEP && $past(power_mode) == ACD_MODE_SLEEP
        && cmp_power_en[0] && $past(cmp_power_en[0]) && $changed(cmp_raw[0])
        |-> $changed(async_wake[0])) else $error("wake path not following input");
    a_dac_cmp_pair: assert property (
        dac_power_en == cmp_power_en) else $error("dac and comparator power differ");
    a_dac_write: assert property (
        reg_wr && reg_addr == ACD_OFS_DAC_BASE
        |=> dac_code[DAC_BITS-1:0] == $past(reg_wdata[DAC_BITS-1:0])) else $error("dac code stale");
    a_pad_needs_power: assert property (
        power_mode == ACD_MODE_RUN |-> (pad_digital_buf_off & ~cmp_power_en) == '0)
        else $error("pad buffer off while unit off");
    c_event: cover property (cmp_out[0].irq_pulse);
    c_wake: cover property (async_wake[0]);
    c_idle_off: cover property (power_mode == ACD_MODE_IDLE && cmp_power_en == '0);
endmodule : acd_top_properties

bind acd_top acd_top_properties #(.NUM_CMP(NUM_CMP), .DAC_BITS(DAC_BITS)) i_props (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .power_mode(power_mode), .cmp_raw(cmp_raw), .cmp_power_en(cmp_power_en),
    .dac_power_en(dac_power_en), .dac_code(dac_code),
    .pad_digital_buf_off(pad_digital_buf_off), .cmp_out(cmp_out), .async_wake(async_wake));

/* File: acd_far_model.sv */
// Far-side consumers: ADC trigger counter and wake detector
`timescale 1ns/1ps
module acd_far_model
    import acd_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire acd_pkg::acd_out_t  evt,
    input  wire logic               async_any,
    output      logic [7:0]         trig_count,
    output      logic               woke
);
    // Count triggers; a stretched pulse shows as an extra count
    always @(posedge clk) begin
        if (srst) begin
            trig_count <= 8'h00;
        end else if (evt.adc_trigger) begin
            trig_count <= trig_count + 8'h01;
        end
    end
    // Wake needs no clock edge, as a sleeping core would have none
    always @(posedge clk or posedge async_any) begin
        if (async_any) begin
            woke <= 1'b1;
        end else if (srst) begin
            woke <= 1'b0;
        end
    end
endmodule : acd_far_model

/* File: test_acd_top.sv */
// Self-checking testbench for the comparator control block
`timescale 1ns/1ps
module test_acd_top;
    import acd_pkg::*;
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pin_en, irq, woke;
    logic [3:0]  reg_addr = 4'h0, cmp_raw = 4'h0, cmp_pwr, dac_pwr, pad_off, wake;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, d;
    logic [39:0] dac_code;
    logic [1:0]  pin_sel;
    logic [7:0]  trig_count;
    acd_mode_t   power_mode = ACD_MODE_RUN;
    acd_out_t [3:0] cmp_out;
    int          fail_count = 0, cmp_count = 0, cyc = 0;
    always #4 clk = ~clk;
    acd_top #(.NUM_CMP(4), .DAC_BITS(10)) i_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_mode(power_mode), .cmp_raw(cmp_raw), .cmp_power_en(cmp_pwr),
        .dac_power_en(dac_pwr), .dac_code(dac_code), .pad_digital_buf_off(pad_off),
        .dac_output_pin_en(pin_en), .dac_output_pin_sel(pin_sel), .cmp_out(cmp_out),
        .async_wake(wake), .irq(irq));
    acd_far_model i_far (.clk(clk), .srst(srst), .evt(cmp_out[0]), .async_any(|wake),
        .trig_count(trig_count), .woke(woke));
    task wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task t_regs;
        rd(ACD_OFS_CONTROL); chk(d, ACD_CONTROL_RESET);
        wr(ACD_OFS_DAC_BASE, 16'h03FF); step(1); chk(dac_code[15:0], 16'h03FF);
        rd(4'hF); chk(d, 16'h0000);
        $display("register test done");
    endtask : t_regs
    task t_filter;
        wr(ACD_OFS_IRQ_MASK, 16'h0001); wr(ACD_OFS_CONTROL, 16'h0001); step(6);
        @(posedge clk) cmp_raw <= 4'h1;
        @(posedge clk) cmp_raw <= 4'h0;
        step(8); chk(16'(cmp_out[0].fault), 16'h0); chk(16'(irq), 16'h0);
        @(posedge clk) cmp_raw <= 4'h1;
        step(8); chk(16'(trig_count), 16'h1);
        chk(16'(cmp_out[0].current_limit), 16'h1); chk(16'(irq), 16'h1);
        rd(ACD_OFS_STATUS); chk(d & 16'h0001, 16'h0001);
        wr(ACD_OFS_IRQ_MASK, 16'h0000); step(1); chk(16'(irq), 16'h0);
        wr(ACD_OFS_IRQ_FLAG, 16'h0001); wr(ACD_OFS_IRQ_MASK, 16'h0001);
        step(1); chk(16'(irq), 16'h0);
        wr(ACD_OFS_CONTROL, 16'h0005); step(8); chk(16'(cmp_out[0].fault), 16'h0);
        @(posedge clk) cmp_raw <= 4'h0;
        step(8); chk(16'(trig_count), 16'h2);
        wr(ACD_OFS_CONTROL, 16'h0001);
        $display("filter test done");
    endtask : t_filter
    task t_power;
        wr(4'h0, 16'h0003); wr(4'h1, 16'h0001); wr(4'h2, 16'h0011); step(1);
        chk(16'(cmp_pwr), 16'h7); chk(16'(pad_off), 16'h4);
        @(posedge clk) power_mode <= ACD_MODE_IDLE;
        step(1); chk(16'(cmp_pwr), 16'h0); chk(16'(dac_pwr), 16'h0);
        @(posedge clk) power_mode <= ACD_MODE_RUN;
        wr(4'h1, 16'h0000); step(1); chk(16'(dac_pwr), 16'h5);
        wr(4'h0, 16'h0001); wr(4'h2, 16'h0000);
        $display("power test done");
    endtask : t_power
    task t_wake;
        @(posedge clk) power_mode <= ACD_MODE_SLEEP;
        step(2);
        @(posedge clk) cmp_raw <= 4'h1;
        #1 chk(16'(wake[0]), 16'h1); chk(16'(woke), 16'h1);
        @(posedge clk) cmp_raw <= 4'h0;
        #1 chk(16'(wake[0]), 16'h0);
        @(posedge clk) power_mode <= ACD_MODE_RUN;
        step(8); chk(16'(wake), 16'h0);
        $display("wake test done");
    endtask : t_wake
    task t_pin;
        wr(4'h1, 16'h0009); step(1);
        chk(16'(pin_en), 16'h1); chk(16'(pin_sel), 16'h1);
        $display("dac pin test done");
    endtask : t_pin
    // Cut a hang short well past the hundred or so cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_regs; t_filter; t_power; t_wake; t_pin;
        wrap_up;
    end
endmodule : test_acd_top
